// *** hw/sob_pkg.sv ***
package sob_pkg;
  localparam logic [6:0] ADDR_THRESH   = 7'h09;
  localparam logic [6:0] ADDR_LINE_CTL = 7'h0d;
  localparam logic [6:0] ADDR_TX_K1    = 7'h10;
  localparam logic [6:0] ADDR_TX_K2    = 7'h11;
  localparam logic [6:0] ADDR_TX_S1    = 7'h12;
  localparam logic [6:0] ADDR_TX_C2    = 7'h13;
  localparam logic [6:0] ADDR_RX_K1    = 7'h14;
  localparam logic [6:0] ADDR_SEC_RING = 7'h6a;
  localparam logic [6:0] ADDR_PTH_RING = 7'h6b;
  localparam logic [7:0] RST_THRESH    = 8'h36;
  localparam logic [7:0] RST_TX_C2     = 8'h13;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [2:0] RDI_PATTERN   = 3'h6;
  localparam int         RDI_BIT       = 2;
  localparam int         TRACE_LEN     = 64;
  localparam int         TRACE_AW      = 6;
  localparam logic [1:0] STS_FIRST     = 2'h0;

  typedef struct packed {
    logic [7:0] aps_one;
    logic [7:0] aps_two;
    logic [7:0] sync_quality;
    logic [7:0] label;
  } sob_tx_oh_type;

  typedef struct packed {
    logic       frame_start;
    logic [1:0] sts_index;
    logic       aps_one_valid;
    logic [7:0] aps_one;
    logic       sec_trace_valid;
    logic [7:0] sec_trace;
    logic       pth_trace_valid;
    logic [7:0] pth_trace;
  } sob_rx_oh_type;

  typedef struct packed {
    logic [7:0]                  thresh;
    logic [7:0]                  line_ctl;
    sob_tx_oh_type               shadow;
    sob_tx_oh_type               live;
    logic [7:0]                  rx_aps_one;
    logic [7:0]                  rx_aps_one_pend;
    logic [TRACE_LEN-1:0][7:0]   sec_ring;
    logic [TRACE_LEN-1:0][7:0]   pth_ring;
    logic [TRACE_AW-1:0]         sec_wr;
    logic [TRACE_AW-1:0]         pth_wr;
    logic [TRACE_AW-1:0]         sec_rd;
    logic [TRACE_AW-1:0]         pth_rd;
    logic [7:0]                  rdata;
  } sob_state_type;
endpackage

// *** hw/sob_overhead_regs.sv ***
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - k1 register sent as k1 octet msb-first
// - k2 register sent as k2 octet msb-first
// - s1 register sent as s1 octet
// - c2 register sent, resets to 0x13
// - k1 k2 s1 only in first sts-1
// - lan variant: aps registers read zero, inert
// - k2 bits 6-8 are ais/rdi field
// - capture 64-byte section trace ring
// - capture 64-byte path trace ring
// - threshold register drives fail/degrade alarms
// - fail exponent bits 7-4, reset 3
// - degrade exponent bits 3-0, reset 6
// - received k1 readable, msb in bit 7
// - section ring also serves sdh trace
// - line rdi forces k2 bits 6-8 to 110
module sob_overhead_regs
  import sob_pkg::*;
#(
  parameter bit WAN_VARIANT = 1'b1
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  input  wire logic [6:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output var  logic [7:0]    reg_rdata,
  input  wire sob_rx_oh_type rx_oh,
  input  wire logic          tx_frame_start,
  input  wire logic [1:0]    tx_sts_index,
  output var  sob_tx_oh_type tx_oh,
  output var  logic          tx_aps_enable,
  output var  logic [3:0]    signal_fail_exponent,
  output var  logic [3:0]    signal_degrade_exponent
);
  sob_state_type st_ff;
  sob_state_type nxt_st;
  logic          wan;
  logic          first_sts;

  assign wan       = WAN_VARIANT;
  assign first_sts = (tx_sts_index == STS_FIRST);

  always_comb begin
    nxt_st = st_ff;
    if (reg_wr) begin
      case (reg_addr)
        // lan variant ignores threshold, k1, k2 and s1 writes
        ADDR_THRESH: if (wan) nxt_st.thresh = reg_wdata;
        ADDR_LINE_CTL: nxt_st.line_ctl = reg_wdata;
        ADDR_TX_K1: if (wan) nxt_st.shadow.aps_one = reg_wdata;
        ADDR_TX_K2: if (wan) nxt_st.shadow.aps_two = reg_wdata;
        ADDR_TX_S1: if (wan) nxt_st.shadow.sync_quality = reg_wdata;
        ADDR_TX_C2: nxt_st.shadow.label = reg_wdata;
        default: ;
      endcase
    end
    if (tx_frame_start) begin
      nxt_st.live = st_ff.shadow;
    end
    if (rx_oh.aps_one_valid && rx_oh.sts_index == STS_FIRST) begin
      nxt_st.rx_aps_one_pend = rx_oh.aps_one;
    end
    if (rx_oh.frame_start) begin
      nxt_st.rx_aps_one = wan ? st_ff.rx_aps_one_pend : RST_ZERO;
    end
    if (rx_oh.sec_trace_valid) begin
      nxt_st.sec_ring[st_ff.sec_wr] = rx_oh.sec_trace;
      nxt_st.sec_wr = st_ff.sec_wr + 1'b1;
    end
    if (rx_oh.pth_trace_valid) begin
      nxt_st.pth_ring[st_ff.pth_wr] = rx_oh.pth_trace;
      nxt_st.pth_wr = st_ff.pth_wr + 1'b1;
    end
    nxt_st.rdata = RST_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_THRESH: nxt_st.rdata = wan ? st_ff.thresh : RST_ZERO;
        ADDR_LINE_CTL: nxt_st.rdata = st_ff.line_ctl;
        ADDR_TX_K1: nxt_st.rdata = wan ? st_ff.shadow.aps_one : RST_ZERO;
        ADDR_TX_K2: nxt_st.rdata = wan ? st_ff.shadow.aps_two : RST_ZERO;
        ADDR_TX_S1: begin
          nxt_st.rdata = wan ? st_ff.shadow.sync_quality : RST_ZERO;
        end
        ADDR_TX_C2: nxt_st.rdata = st_ff.shadow.label;
        ADDR_RX_K1: nxt_st.rdata = wan ? st_ff.rx_aps_one : RST_ZERO;
        ADDR_SEC_RING: begin
          nxt_st.rdata = st_ff.sec_ring[st_ff.sec_rd];
          nxt_st.sec_rd = st_ff.sec_rd + 1'b1;
        end
        ADDR_PTH_RING: begin
          nxt_st.rdata = st_ff.pth_ring[st_ff.pth_rd];
          nxt_st.pth_rd = st_ff.pth_rd + 1'b1;
        end
        default: nxt_st.rdata = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.thresh <= RST_THRESH;
      st_ff.shadow.label <= RST_TX_C2;
      st_ff.live.label <= RST_TX_C2;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;

  always_comb begin
    tx_oh = st_ff.live;
    if (st_ff.line_ctl[RDI_BIT]) begin
      tx_oh.aps_two[2:0] = RDI_PATTERN;
    end
    if (!(wan && first_sts)) begin
      tx_oh.aps_one = RST_ZERO;
      tx_oh.aps_two = RST_ZERO;
      tx_oh.sync_quality = RST_ZERO;
    end
  end

  assign tx_aps_enable = wan && first_sts;

  assign signal_fail_exponent    = wan ? st_ff.thresh[7:4] : 4'h0;
  assign signal_degrade_exponent = wan ? st_ff.thresh[3:0] : 4'h0;

  property p_read_one_cycle;
    @(posedge clk_sys) disable iff (sys_rst)
      (clk_en && !reg_rd) |=> (reg_rdata == 8'h00);
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("read data not cleared");

  property p_rdi;
    @(posedge clk_sys) disable iff (sys_rst)
      (st_ff.line_ctl[RDI_BIT] && wan && first_sts)
        |-> (tx_oh.aps_two[2:0] == 3'h6);
  endproperty
  a_rdi: assert property (p_rdi)
    else $error("rdi pattern missing");

  property p_first_sts;
    @(posedge clk_sys) disable iff (sys_rst)
      !first_sts |-> (tx_oh.aps_one == 8'h00 && tx_oh.sync_quality == 8'h00);
  endproperty
  a_first_sts: assert property (p_first_sts)
    else $error("aps bytes outside first sts");

  property p_frame_sample;
    @(posedge clk_sys) disable iff (sys_rst)
      (clk_en && tx_frame_start) |=> (st_ff.live == $past(st_ff.shadow));
  endproperty
  a_frame_sample: assert property (p_frame_sample)
    else $error("frame sample wrong");

  property p_live_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      !tx_frame_start |=> $stable(st_ff.live);
  endproperty
  a_live_hold: assert property (p_live_hold)
    else $error("live octets changed mid frame");

  property p_label;
    @(posedge clk_sys) disable iff (sys_rst)
      1'b1 |-> (tx_oh.label == st_ff.live.label);
  endproperty
  a_label: assert property (p_label)
    else $error("label octet mismatch");

  property p_exponents;
    @(posedge clk_sys) disable iff (sys_rst)
      wan |-> (signal_fail_exponent == st_ff.thresh[7:4]
               && signal_degrade_exponent == st_ff.thresh[3:0]);
  endproperty
  a_exponents: assert property (p_exponents)
    else $error("exponent fields wrong");

  property p_sec_ring;
    @(posedge clk_sys) disable iff (sys_rst)
      (clk_en && rx_oh.sec_trace_valid)
        |=> (st_ff.sec_ring[$past(st_ff.sec_wr)] == $past(rx_oh.sec_trace));
  endproperty
  a_sec_ring: assert property (p_sec_ring)
    else $error("section trace not captured");

  property p_pth_ring;
    @(posedge clk_sys) disable iff (sys_rst)
      (clk_en && rx_oh.pth_trace_valid)
        |=> (st_ff.pth_wr == $past(st_ff.pth_wr) + 6'h01);
  endproperty
  a_pth_ring: assert property (p_pth_ring)
    else $error("path trace pointer stuck");

  sequence s_k1_read;
    clk_en && reg_rd && reg_addr == ADDR_RX_K1;
  endsequence
  sequence s_sec_read;
    clk_en && reg_rd && reg_addr == ADDR_SEC_RING;
  endsequence
  sequence s_pth_read;
    clk_en && reg_rd && reg_addr == ADDR_PTH_RING;
  endsequence
  sequence s_rx_frame;
    clk_en && rx_oh.frame_start;
  endsequence
  sequence s_thresh_write;
    clk_en && reg_wr && reg_addr == ADDR_THRESH;
  endsequence

  property p_k1_read;
    @(posedge clk_sys) disable iff (sys_rst)
      s_k1_read
        |=> (reg_rdata == (wan ? $past(st_ff.rx_aps_one) : 8'h00));
  endproperty
  a_k1_read: assert property (p_k1_read)
    else $error("received k1 read wrong");

  property p_k1_publish;
    @(posedge clk_sys) disable iff (sys_rst)
      s_rx_frame |=> (st_ff.rx_aps_one
        == (wan ? $past(st_ff.rx_aps_one_pend) : 8'h00));
  endproperty
  a_k1_publish: assert property (p_k1_publish)
    else $error("received k1 not published at frame");

  property p_k1_other_sts;
    @(posedge clk_sys) disable iff (sys_rst)
      (clk_en && rx_oh.aps_one_valid && rx_oh.sts_index != STS_FIRST)
        |=> $stable(st_ff.rx_aps_one_pend);
  endproperty
  a_k1_other_sts: assert property (p_k1_other_sts)
    else $error("k1 taken from other sts");

  property p_sec_read;
    @(posedge clk_sys) disable iff (sys_rst)
      s_sec_read
        |=> (reg_rdata == $past(st_ff.sec_ring[st_ff.sec_rd])
             && st_ff.sec_rd == $past(st_ff.sec_rd) + 6'h01);
  endproperty
  a_sec_read: assert property (p_sec_read)
    else $error("section ring read wrong");

  property p_pth_read;
    @(posedge clk_sys) disable iff (sys_rst)
      s_pth_read
        |=> (reg_rdata == $past(st_ff.pth_ring[st_ff.pth_rd])
             && st_ff.pth_rd == $past(st_ff.pth_rd) + 6'h01);
  endproperty
  a_pth_read: assert property (p_pth_read)
    else $error("path ring read wrong");

  property p_pth_data;
    @(posedge clk_sys) disable iff (sys_rst)
      (clk_en && rx_oh.pth_trace_valid)
        |=> (st_ff.pth_ring[$past(st_ff.pth_wr)] == $past(rx_oh.pth_trace));
  endproperty
  a_pth_data: assert property (p_pth_data)
    else $error("path trace not captured");

  property p_sec_step;
    @(posedge clk_sys) disable iff (sys_rst)
      (clk_en && rx_oh.sec_trace_valid)
        |=> (st_ff.sec_wr == $past(st_ff.sec_wr) + 6'h01);
  endproperty
  a_sec_step: assert property (p_sec_step)
    else $error("section trace pointer stuck");

  property p_thresh_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_thresh_write |=> (st_ff.thresh
        == (wan ? $past(reg_wdata) : $past(st_ff.thresh)));
  endproperty
  a_thresh_write: assert property (p_thresh_write)
    else $error("threshold write wrong");

  property p_k1_octet;
    @(posedge clk_sys) disable iff (sys_rst)
      (wan && first_sts) |-> (tx_oh.aps_one == st_ff.live.aps_one);
  endproperty
  a_k1_octet: assert property (p_k1_octet)
    else $error("k1 octet wrong");

  property p_s1_octet;
    @(posedge clk_sys) disable iff (sys_rst)
      (wan && first_sts) |-> (tx_oh.sync_quality == st_ff.live.sync_quality);
  endproperty
  a_s1_octet: assert property (p_s1_octet)
    else $error("s1 octet wrong");

  property p_k2_octet;
    @(posedge clk_sys) disable iff (sys_rst)
      (wan && first_sts && !st_ff.line_ctl[RDI_BIT])
        |-> (tx_oh.aps_two == st_ff.live.aps_two);
  endproperty
  a_k2_octet: assert property (p_k2_octet)
    else $error("k2 octet wrong");

  property p_k2_upper;
    @(posedge clk_sys) disable iff (sys_rst)
      (wan && first_sts)
        |-> (tx_oh.aps_two[7:3] == st_ff.live.aps_two[7:3]);
  endproperty
  a_k2_upper: assert property (p_k2_upper)
    else $error("k2 switching bits disturbed");

  property p_lan_quiet;
    @(posedge clk_sys) disable iff (sys_rst)
      !wan |-> (tx_oh.aps_one == 8'h00 && tx_oh.aps_two == 8'h00
                && tx_oh.sync_quality == 8'h00
                && signal_fail_exponent == 4'h0
                && signal_degrade_exponent == 4'h0);
  endproperty
  a_lan_quiet: assert property (p_lan_quiet)
    else $error("lan variant aps outputs active");

  property p_lan_rx_k1;
    @(posedge clk_sys) disable iff (sys_rst)
      !wan |-> (st_ff.rx_aps_one == 8'h00);
  endproperty
  a_lan_rx_k1: assert property (p_lan_rx_k1)
    else $error("lan variant received k1 nonzero");

  property p_freeze;
    @(posedge clk_sys) disable iff (sys_rst)
      !clk_en |=> $stable(st_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state changed while frozen");
endmodule
`default_nettype wire

// *** test/sob_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module sob_far_end
  import sob_pkg::*;
(
  input  wire logic    clk_sys,
  output var  sob_rx_oh_type rx_oh
);
  initial rx_oh = '0;
  // kind 0 k1, 1 section, 2 path, 3 frame start, 4 k1 in sts 1
  task automatic put(input int kind, input logic [7:0] b);
    sob_rx_oh_type idle;
    @(posedge clk_sys);
    rx_oh.sts_index <= (kind == 4) ? 2'h1 : STS_FIRST;
    case (kind)
      0, 4: begin
        rx_oh.aps_one_valid <= 1'b1;
        rx_oh.aps_one       <= b;
      end
      1: begin
        rx_oh.sec_trace_valid <= 1'b1;
        rx_oh.sec_trace       <= b;
      end
      2: begin
        rx_oh.pth_trace_valid <= 1'b1;
        rx_oh.pth_trace       <= b;
      end
      default: rx_oh.frame_start <= 1'b1;
    endcase
    @(posedge clk_sys);
    // released lines no longer show the last octet
    idle           = '0;
    idle.aps_one   = ~b;
    idle.sec_trace = ~b;
    idle.pth_trace = ~b;
    rx_oh <= idle;
  endtask
endmodule
`default_nettype wire

// *** test/test_sonet_overhead_byte_access.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_sonet_overhead_byte_access;
  import sob_pkg::*;
  logic          clk_sys = 1'b0;
  logic          sys_rst = 1'b1;
  logic          clk_en = 1'b1;
  logic [6:0]    reg_addr = 7'h00;
  logic [7:0]    reg_wdata = 8'h00;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [7:0]    reg_rdata;
  sob_rx_oh_type rx_oh;
  logic          tx_frame_start = 1'b0;
  logic [1:0]    tx_sts_index = 2'h0;
  sob_tx_oh_type tx_oh;
  logic          tx_aps_enable;
  logic [3:0]    signal_fail_exponent;
  logic [3:0]    signal_degrade_exponent;
  logic [7:0]    lan_rdata;
  sob_tx_oh_type lan_tx_oh;
  logic          lan_aps_enable;
  logic [3:0]    lan_fail_exp;
  logic [3:0]    lan_degrade_exp;
  int            fails = 0;
  int            comparisons = 0;

  sob_overhead_regs dut (.clk_sys, .sys_rst, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_oh, .tx_frame_start,
    .tx_sts_index, .tx_oh, .tx_aps_enable, .signal_fail_exponent,
    .signal_degrade_exponent);
  sob_overhead_regs #(.WAN_VARIANT(1'b0)) dut_lan (.clk_sys, .sys_rst,
    .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(lan_rdata), .rx_oh, .tx_frame_start, .tx_sts_index,
    .tx_oh(lan_tx_oh), .tx_aps_enable(lan_aps_enable),
    .signal_fail_exponent(lan_fail_exp),
    .signal_degrade_exponent(lan_degrade_exp));
  sob_far_end far (.clk_sys, .rx_oh);

  initial forever #12.5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, string nm);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic frame;
    @(posedge clk_sys);
    tx_frame_start <= 1'b1;
    tx_sts_index   <= 2'h0;
    @(posedge clk_sys);
    tx_frame_start <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    wrap_up;
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_THRESH, 8'h36, "thresh");
    chk("sf_exp", {4'h0, signal_fail_exponent}, 8'h03);
    chk("sd_exp", {4'h0, signal_degrade_exponent}, 8'h06);
    rd(ADDR_TX_C2, 8'h13, "label");
    rd(ADDR_TX_K1, 8'h00, "aps_one");
    rd(7'h20, 8'h00, "unmapped");
    wr(ADDR_THRESH, 8'h9a);
    rd(ADDR_THRESH, 8'h9a, "thresh");
    chk("lan_thresh", lan_rdata, 8'h00);
    chk("lan_sf", {4'h0, lan_fail_exp}, 8'h00);
    chk("lan_sd", {4'h0, lan_degrade_exp}, 8'h00);
    chk("sf_exp", {4'h0, signal_fail_exponent}, 8'h09);
    chk("sd_exp", {4'h0, signal_degrade_exponent}, 8'h0a);
    wr(ADDR_TX_K1, 8'ha5);
    wr(ADDR_TX_K2, 8'h3c);
    wr(ADDR_TX_S1, 8'h0f);
    wr(ADDR_TX_C2, 8'he2);
    chk("tx_label", tx_oh.label, 8'h13);
    frame;
    chk("tx_k1", tx_oh.aps_one, 8'ha5);
    chk("tx_k2", tx_oh.aps_two, 8'h3c);
    chk("tx_s1", tx_oh.sync_quality, 8'h0f);
    chk("tx_label", tx_oh.label, 8'he2);
    chk("aps_en", {7'h00, tx_aps_enable}, 8'h01);
    chk("lan_k1", lan_tx_oh.aps_one, 8'h00);
    chk("lan_label", lan_tx_oh.label, 8'he2);
    chk("lan_aps_en", {7'h00, lan_aps_enable}, 8'h00);
    @(posedge clk_sys);
    tx_sts_index <= 2'h1;
    #1 chk("tx_k1", tx_oh.aps_one, 8'h00);
    chk("tx_k2", tx_oh.aps_two, 8'h00);
    chk("tx_s1", tx_oh.sync_quality, 8'h00);
    wr(ADDR_LINE_CTL, 8'h04);
    frame;
    chk("tx_k2_rdi", tx_oh.aps_two, 8'h3e);
    far.put(0, 8'h5b);
    rd(ADDR_RX_K1, 8'h00, "rx_k1");
    far.put(3, 8'h00);
    rd(ADDR_RX_K1, 8'h5b, "rx_k1");
    chk("lan_rx_k1", lan_rdata, 8'h00);
    far.put(4, 8'hc3);
    far.put(3, 8'h00);
    rd(ADDR_RX_K1, 8'h5b, "rx_k1_sts");
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(ADDR_TX_S1, 8'h77);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(ADDR_TX_S1, 8'h0f, "s1_frozen");
    for (int i = 0; i < 66; i++) far.put(1, i[7:0]);
    rd(ADDR_SEC_RING, 8'h40, "sec_ring");
    rd(ADDR_SEC_RING, 8'h41, "sec_ring");
    rd(ADDR_SEC_RING, 8'h02, "sec_ring");
    for (int i = 0; i < 64; i++) far.put(2, 8'h80 | i[7:0]);
    rd(ADDR_PTH_RING, 8'h80, "pth_ring");
    rd(ADDR_PTH_RING, 8'h81, "pth_ring");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_TX_C2, 8'h13, "label_rst");
    rd(ADDR_THRESH, 8'h36, "thresh_rst");
    wrap_up;
  end
endmodule
`default_nettype wire
